// file: tsb_pkg.sv
package tsb_pkg;

  // ----------------------------------------------------------------
  // Pointer values
  // ----------------------------------------------------------------
  localparam logic [7:0] P_LOC_HI   = 8'h00;
  localparam logic [7:0] P_REM_HI   = 8'h01;
  localparam logic [7:0] P_STATUS   = 8'h02;
  localparam logic [7:0] P_SETUP_RD = 8'h03;
  localparam logic [7:0] P_RATE_RD  = 8'h04;
  localparam logic [7:0] P_LUH_RD   = 8'h05;
  localparam logic [7:0] P_LLH_RD   = 8'h06;
  localparam logic [7:0] P_RUH_RD   = 8'h07;
  localparam logic [7:0] P_RLH_RD   = 8'h08;
  localparam logic [7:0] P_SETUP_WR = 8'h09;
  localparam logic [7:0] P_RATE_WR  = 8'h0A;
  localparam logic [7:0] P_LUH_WR   = 8'h0B;
  localparam logic [7:0] P_LLH_WR   = 8'h0C;
  localparam logic [7:0] P_RUH_WR   = 8'h0D;
  localparam logic [7:0] P_RLH_WR   = 8'h0E;
  localparam logic [7:0] P_ONESHOT  = 8'h0F;
  localparam logic [7:0] P_REM_LO   = 8'h10;
  localparam logic [7:0] P_RUL      = 8'h13;
  localparam logic [7:0] P_RLL      = 8'h14;
  localparam logic [7:0] P_LOC_LO   = 8'h15;
  localparam logic [7:0] P_LUL      = 8'h16;
  localparam logic [7:0] P_LLL      = 8'h17;
  localparam logic [7:0] P_NCORR    = 8'h18;
  localparam logic [7:0] P_ROVH     = 8'h19;
  localparam logic [7:0] P_RES      = 8'h1A;

  // ----------------------------------------------------------------
  // Reset values, writable bits and fixed bits
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PTR      = 8'h00;
  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam logic [7:0] RST_SETUP    = 8'h00;
  localparam logic [7:0] RST_RATE     = 8'h08;
  localparam logic [7:0] RST_HIGH_LIM = 8'h55;
  localparam logic [7:0] RST_RES      = 8'h1C;
  localparam logic [7:0] RD_UNMAPPED  = 8'h00;
  localparam logic [7:0] WM_SETUP     = 8'hE4;
  localparam logic [7:0] WM_RATE      = 8'h0F;
  localparam logic [7:0] WM_LIMIT_LO  = 8'hF0;
  localparam logic [7:0] WM_RES       = 8'h03;
  localparam logic [7:0] WM_ALL       = 8'hFF;
  localparam logic [7:0] FIX_RES      = 8'h1C;
  localparam logic [7:0] FIX_NONE     = 8'h00;

  // Local fraction masks, by resolution select code.
  localparam logic [7:0] FRAC_HALF    = 8'h80;
  localparam logic [7:0] FRAC_QUARTER = 8'hC0;
  localparam logic [7:0] FRAC_EIGHTH  = 8'hE0;
  localparam logic [7:0] FRAC_SIXTNTH = 8'hF0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       ptr_wr;
    logic       data_wr;
    logic       rd;
    logic [7:0] data;
  } tsb_link_s;

  typedef struct packed {
    logic        local_done;
    logic [11:0] local_result_bits;
    logic        remote_done;
    logic [11:0] remote_result_bits;
  } tsb_conv_s;

  typedef struct packed {
    logic [7:0] device_setup;
    logic [7:0] sample_rate_select;
    logic [7:0] local_upper_limit_high;
    logic [7:0] local_lower_limit_high;
    logic [7:0] remote_upper_limit_high;
    logic [7:0] remote_lower_limit_high;
    logic [7:0] remote_upper_limit_low;
    logic [7:0] remote_lower_limit_low;
    logic [7:0] local_upper_limit_low;
    logic [7:0] local_lower_limit_low;
    logic [7:0] ideality_correction;
    logic [7:0] remote_overheat_limit;
    logic [7:0] local_fraction_select;
  } tsb_ctrl_s;

endpackage : tsb_pkg

// file: tsb_reg_bank.sv
`timescale 1ns/1ns
`default_nettype none

module tsb_reg_bank #(
  parameter logic [7:0] HIGH_LIMIT_RESET = tsb_pkg::RST_HIGH_LIM
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              sys_rst,
  // Byte requests from the two-wire front end
  input  wire tsb_pkg::tsb_link_s link,
  output logic             [7:0] rd_data,
  output logic                   rd_valid,
  // Converter side
  input  wire tsb_pkg::tsb_conv_s conv,
  input  wire logic        [7:0] event_flags,
  output logic                   start_single,
  // Register contents that steer the converter and comparators
  output tsb_pkg::tsb_ctrl_s     ctrl,
  output logic             [7:0] pointer
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] frac_mask(input logic [1:0] sel);
    case (sel)
      2'h0:    frac_mask = tsb_pkg::FRAC_HALF;
      2'h1:    frac_mask = tsb_pkg::FRAC_QUARTER;
      2'h2:    frac_mask = tsb_pkg::FRAC_EIGHTH;
      default: frac_mask = tsb_pkg::FRAC_SIXTNTH;
    endcase
  endfunction : frac_mask

  function automatic logic [7:0] low_byte(input logic [3:0] nib);
    low_byte = {nib, 4'h0};
  endfunction : low_byte

  function automatic logic [7:0] fixed_bits(input logic [7:0] d,
                                            input logic [7:0] wm,
                                            input logic [7:0] fix);
    fixed_bits = (d & wm) | fix;
  endfunction : fixed_bits

  // ----------------------------------------------------------------
  // Result storage
  // ----------------------------------------------------------------
  logic [11:0] local_result;
  logic [11:0] remote_result;
  logic [3:0]  hold_nib;
  logic        hold_remote;
  logic        hold_valid;
  logic [7:0]  next_rd_data;
  logic [7:0]  loc_frac_mask;
  logic        rd_loc_hi;
  logic        rd_rem_hi;

  assign loc_frac_mask = frac_mask(ctrl.local_fraction_select[1:0]);
  assign rd_loc_hi     = link.rd && (pointer == tsb_pkg::P_LOC_HI);
  assign rd_rem_hi     = link.rd && (pointer == tsb_pkg::P_REM_HI);

  // ----------------------------------------------------------------
  // Pointer
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      pointer <= tsb_pkg::RST_PTR;
    else if (link.ptr_wr)
      pointer <= link.data;
  end

  // ----------------------------------------------------------------
  // Conversion results
  // ----------------------------------------------------------------
  // Only reset and the converter strobes move these; link writes never reach them.
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      local_result  <= 12'h000;
      remote_result <= 12'h000;
    end
    else
    begin
      if (conv.local_done)
        local_result <= conv.local_result_bits;
      if (conv.remote_done)
        remote_result <= conv.remote_result_bits;
    end
  end

  // ----------------------------------------------------------------
  // Same-conversion low byte snapshot
  // ----------------------------------------------------------------
  // A new conversion may land between the high and low reads, so the
  // low nibble is frozen when the high byte goes out. Any other read
  // drops the snapshot, matching the lapse of the guarantee.
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      hold_nib    <= 4'h0;
      hold_remote <= 1'b0;
      hold_valid  <= 1'b0;
    end
    else if (rd_loc_hi)
    begin
      hold_nib    <= local_result[3:0];
      hold_remote <= 1'b0;
      hold_valid  <= 1'b1;
    end
    else if (rd_rem_hi)
    begin
      hold_nib    <= remote_result[3:0];
      hold_remote <= 1'b1;
      hold_valid  <= 1'b1;
    end
    else if (link.rd)
      hold_valid <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  // Write-only and unmapped pointers, including the write aliases,
  // read as zero.
  always_comb
  begin
    case (pointer)
      tsb_pkg::P_LOC_HI:   next_rd_data = local_result[11:4];
      tsb_pkg::P_REM_HI:   next_rd_data = remote_result[11:4];
      tsb_pkg::P_STATUS:   next_rd_data = event_flags;
      tsb_pkg::P_SETUP_RD: next_rd_data = ctrl.device_setup;
      tsb_pkg::P_RATE_RD:  next_rd_data = ctrl.sample_rate_select;
      tsb_pkg::P_LUH_RD:   next_rd_data = ctrl.local_upper_limit_high;
      tsb_pkg::P_LLH_RD:   next_rd_data = ctrl.local_lower_limit_high;
      tsb_pkg::P_RUH_RD:   next_rd_data = ctrl.remote_upper_limit_high;
      tsb_pkg::P_RLH_RD:   next_rd_data = ctrl.remote_lower_limit_high;
      tsb_pkg::P_REM_LO:
        if (hold_valid && hold_remote)
          next_rd_data = low_byte(hold_nib);
        else
          next_rd_data = low_byte(remote_result[3:0]);
      tsb_pkg::P_LOC_LO:
        if (hold_valid && !hold_remote)
          next_rd_data = low_byte(hold_nib) & loc_frac_mask;
        else
          next_rd_data = low_byte(local_result[3:0])
                         & loc_frac_mask;
      tsb_pkg::P_RUL:      next_rd_data = ctrl.remote_upper_limit_low;
      tsb_pkg::P_RLL:      next_rd_data = ctrl.remote_lower_limit_low;
      tsb_pkg::P_LUL:      next_rd_data = ctrl.local_upper_limit_low;
      tsb_pkg::P_LLL:      next_rd_data = ctrl.local_lower_limit_low;
      tsb_pkg::P_NCORR:    next_rd_data = ctrl.ideality_correction;
      tsb_pkg::P_ROVH:     next_rd_data = ctrl.remote_overheat_limit;
      tsb_pkg::P_RES:      next_rd_data = ctrl.local_fraction_select;
      default:             next_rd_data = tsb_pkg::RD_UNMAPPED;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rd_data  <= tsb_pkg::RST_ZERO;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_valid <= link.rd;
      if (link.rd)
        rd_data <= next_rd_data;
    end
  end

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  // Writes to read-only pointers and to unmapped ones fall into the
  // default branch and change nothing.
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      ctrl.device_setup            <= tsb_pkg::RST_SETUP;
      ctrl.sample_rate_select      <= tsb_pkg::RST_RATE;
      ctrl.local_upper_limit_high  <= HIGH_LIMIT_RESET;
      ctrl.local_lower_limit_high  <= tsb_pkg::RST_ZERO;
      ctrl.remote_upper_limit_high <= HIGH_LIMIT_RESET;
      ctrl.remote_lower_limit_high <= tsb_pkg::RST_ZERO;
      ctrl.remote_upper_limit_low  <= tsb_pkg::RST_ZERO;
      ctrl.remote_lower_limit_low  <= tsb_pkg::RST_ZERO;
      ctrl.local_upper_limit_low   <= tsb_pkg::RST_ZERO;
      ctrl.local_lower_limit_low   <= tsb_pkg::RST_ZERO;
      ctrl.ideality_correction     <= tsb_pkg::RST_ZERO;
      ctrl.remote_overheat_limit   <= HIGH_LIMIT_RESET;
      ctrl.local_fraction_select   <= tsb_pkg::RST_RES;
    end
    else if (link.data_wr)
    begin
      case (pointer)
        tsb_pkg::P_SETUP_WR:
          ctrl.device_setup <= fixed_bits(link.data, tsb_pkg::WM_SETUP,
                                          tsb_pkg::FIX_NONE);
        tsb_pkg::P_RATE_WR:
          ctrl.sample_rate_select <= fixed_bits(link.data,
                                       tsb_pkg::WM_RATE,
                                       tsb_pkg::FIX_NONE);
        tsb_pkg::P_LUH_WR:
          ctrl.local_upper_limit_high  <= link.data;
        tsb_pkg::P_LLH_WR:
          ctrl.local_lower_limit_high  <= link.data;
        tsb_pkg::P_RUH_WR:
          ctrl.remote_upper_limit_high <= link.data;
        tsb_pkg::P_RLH_WR:
          ctrl.remote_lower_limit_high <= link.data;
        tsb_pkg::P_RUL:
          ctrl.remote_upper_limit_low <= fixed_bits(link.data,
                                           tsb_pkg::WM_LIMIT_LO,
                                           tsb_pkg::FIX_NONE);
        tsb_pkg::P_RLL:
          ctrl.remote_lower_limit_low <= fixed_bits(link.data,
                                           tsb_pkg::WM_LIMIT_LO,
                                           tsb_pkg::FIX_NONE);
        tsb_pkg::P_LUL:
          ctrl.local_upper_limit_low <= fixed_bits(link.data,
                                          tsb_pkg::WM_LIMIT_LO,
                                          tsb_pkg::FIX_NONE);
        tsb_pkg::P_LLL:
          ctrl.local_lower_limit_low <= fixed_bits(link.data,
                                          tsb_pkg::WM_LIMIT_LO,
                                          tsb_pkg::FIX_NONE);
        tsb_pkg::P_NCORR:
          ctrl.ideality_correction <= fixed_bits(link.data,
                                        tsb_pkg::WM_ALL,
                                        tsb_pkg::FIX_NONE);
        tsb_pkg::P_ROVH:
          ctrl.remote_overheat_limit <= link.data;
        tsb_pkg::P_RES:
          ctrl.local_fraction_select <= fixed_bits(link.data,
                                          tsb_pkg::WM_RES,
                                          tsb_pkg::FIX_RES);
        default:
          ctrl.device_setup <= ctrl.device_setup;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // One-shot trigger
  // ----------------------------------------------------------------
  // The data byte is a don't-care and is not kept anywhere.
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      start_single <= 1'b0;
    else
      start_single <= link.data_wr
                      && (pointer == tsb_pkg::P_ONESHOT);
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_pointer_load:
    assert property (link.ptr_wr |=> pointer == $past(link.data))
    else $error("pointer did not take the first write byte");

  a_pointer_reset:
    assert property (disable iff (1'b0)
      sys_rst |=> pointer == tsb_pkg::RST_PTR)
    else $error("pointer not cleared by reset");

  a_read_answer:
    assert property (link.rd |=> rd_valid ##1 !rd_valid || $past(link.rd))
    else $error("read answer not one cycle after request");

  a_local_frac:
    assert property ((link.rd && pointer == tsb_pkg::P_LOC_LO)
      |=> (rd_data & ~$past(loc_frac_mask)) == 8'h00)
    else $error("local fraction carries bits below resolution");

  a_remote_low:
    assert property ((link.rd && pointer == tsb_pkg::P_REM_LO
                      && !hold_valid)
      |=> rd_data == {$past(remote_result[3:0]), 4'h0})
    else $error("remote low byte encoding wrong");

  // The host idles one cycle after each transfer, so the pointer write
  // for the low byte comes two cycles after the high read.
  a_same_conv:
    assert property (rd_loc_hi
      ##2 (link.ptr_wr && link.data == tsb_pkg::P_LOC_LO)
      ##1 link.rd
      |=> rd_data == ({$past(local_result[3:0], 4), 4'h0}
                      & $past(loc_frac_mask)))
    else $error("low byte not from the high byte's conversion");

  a_setup_alias:
    assert property ((link.data_wr && pointer == tsb_pkg::P_SETUP_WR)
      |=> ctrl.device_setup == ($past(link.data) & tsb_pkg::WM_SETUP))
    else $error("setup write alias failed");

  a_result_ro:
    assert property ((!conv.local_done && !conv.remote_done)
      |=> $stable(local_result) && $stable(remote_result))
    else $error("result changed without a conversion");

  a_oneshot_pulse:
    assert property ((link.data_wr && pointer == tsb_pkg::P_ONESHOT)
      |=> start_single ##1 (!start_single || $past(link.data_wr)))
    else $error("one-shot write did not give one pulse");

  a_fixed_bits:
    assert property (ctrl.local_fraction_select[7:2] == 6'h07
      && ctrl.local_upper_limit_low[3:0] == 4'h0
      && ctrl.sample_rate_select[7:4] == 4'h0)
    else $error("fixed register bits changed");

endmodule : tsb_reg_bank

`default_nettype wire

// file: tsb_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module tsb_host_model (
  // Clock
  input  wire logic              clock,
  // Requests toward the register bank
  output var tsb_pkg::tsb_link_s link,
  // Read answer
  input  wire logic        [7:0] rd_data,
  input  wire logic              rd_valid
);

  initial
  begin
    link = '0;
  end

  // ----------------------------------------------------------------
  // Byte requests, each launched on a falling edge
  // ----------------------------------------------------------------
  task automatic step(input logic pw, input logic dw, input logic r,
                      input logic [7:0] d);
    link.ptr_wr  = pw;
    link.data_wr = dw;
    link.rd      = r;
    link.data    = d;
    @(negedge clock);
  endtask : step

  // A released data bus shows the inverse byte so stale data never matches.
  task automatic release_bus();
    link.ptr_wr  = 1'b0;
    link.data_wr = 1'b0;
    link.rd      = 1'b0;
    link.data    = ~link.data;
    @(negedge clock);
  endtask : release_bus

  task automatic write_reg(input logic [7:0] p, input logic [7:0] d);
    step(1'b1, 1'b0, 1'b0, p);
    step(1'b0, 1'b1, 1'b0, d);
    release_bus();
  endtask : write_reg

  task automatic read_here(output logic [7:0] d, output logic v);
    step(1'b0, 1'b0, 1'b1, ~link.data);
    d = rd_data;
    v = rd_valid;
    release_bus();
  endtask : read_here

  task automatic read_reg(input logic [7:0] p, output logic [7:0] d,
                          output logic v);
    step(1'b1, 1'b0, 1'b0, p);
    step(1'b0, 1'b0, 1'b1, ~p);
    d = rd_data;
    v = rd_valid;
    release_bus();
  endtask : read_reg

endmodule : tsb_host_model

`default_nettype wire

// file: tb.sv
`timescale 1ns/1ns
`default_nettype none

module tb;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  // The alternate variant value is used so a hard-wired default shows.
  localparam logic [7:0] HLR = 8'h6E;
  localparam logic [7:0] EVF = 8'hA5;

  logic               clock;
  logic               sys_rst;
  tsb_pkg::tsb_link_s link;
  tsb_pkg::tsb_conv_s conv;
  tsb_pkg::tsb_ctrl_s ctrl;
  logic         [7:0] event_flags;
  logic         [7:0] rd_data;
  logic         [7:0] pointer;
  logic               rd_valid;
  logic               start_single;
  int                 err_total;
  int                 cmp_count;
  int                 starts = 0;
  int                 s0;
  logic         [7:0] got;
  logic               vld;
  logic         [7:0] wp [13] = '{8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E,
                                  8'h13, 8'h14, 8'h16, 8'h17, 8'h18, 8'h19,
                                  8'h1A};
  logic         [7:0] rp [13] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
                                  8'h13, 8'h14, 8'h16, 8'h17, 8'h18, 8'h19,
                                  8'h1A};
  logic         [7:0] ex [13] = '{8'hE4, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
                                  8'hF0, 8'hF0, 8'hF0, 8'hF0, 8'hFF, 8'hFF,
                                  8'h1F};
  logic         [7:0] ro [6]  = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h15, 8'h1B};
  logic         [7:0] fm [4]  = '{8'h80, 8'hC0, 8'hE0, 8'hF0};

  tsb_reg_bank #(.HIGH_LIMIT_RESET(HLR)) tsb_reg_bank_inst (
    .clock(clock), .sys_rst(sys_rst), .link(link), .rd_data(rd_data),
    .rd_valid(rd_valid), .conv(conv), .event_flags(event_flags),
    .start_single(start_single), .ctrl(ctrl), .pointer(pointer));

  tsb_host_model tsb_host_model_inst (
    .clock(clock), .link(link), .rd_data(rd_data), .rd_valid(rd_valid));

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  always @(posedge clock)
    if (start_single === 1'b1)
      starts <= starts + 1;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] rst_val(input logic [7:0] p);
    case (p)
      8'h02:               return EVF;
      8'h04:               return 8'h08;
      8'h05, 8'h07, 8'h19: return HLR;
      8'h1A:               return 8'h1C;
      default:             return 8'h00;
    endcase
  endfunction : rst_val

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] act);
    cmp_count++;
    if (act !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, act);
    end
  endtask : chk

  // A read without its valid pulse is turned into an unknown that fails.
  task automatic rd_chk(input string what, input logic [7:0] p,
                        input logic [7:0] exp);
    tsb_host_model_inst.read_reg(p, got, vld);
    chk(what, exp, (vld === 1'b1) ? got : 8'hXX);
  endtask : rd_chk

  task automatic conv_pulse(input logic rem, input logic [11:0] t);
    conv.local_done         = ~rem;
    conv.remote_done        = rem;
    conv.local_result_bits  = t;
    conv.remote_result_bits = t;
    @(negedge clock);
    conv.local_done  = 1'b0;
    conv.remote_done = 1'b0;
    @(negedge clock);
  endtask : conv_pulse

  task automatic done_test(input string name);
    $display("test %s finished, mismatches so far %0d", name, err_total);
  endtask : done_test

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    sys_rst = 1'b1;
    event_flags = EVF;
    conv = '0;
    err_total = 0;
    cmp_count = 0;
    repeat (10) @(negedge clock);
    sys_rst = 1'b0;
    chk("pointer at reset", 8'h00, pointer);
    tsb_host_model_inst.read_here(got, vld);
    chk("first read", 8'h00, (vld === 1'b1) ? got : 8'hXX);
    for (int p = 0; p < 28; p++)
      rd_chk("reset value", p[7:0], rst_val(p[7:0]));
    chk("pointer held", 8'h1B, pointer);
    done_test("reset values");
    for (int k = 0; k < 13; k++)
      tsb_host_model_inst.write_reg(wp[k], 8'hFF);
    for (int k = 0; k < 13; k++)
      rd_chk("written", rp[k], ex[k]);
    chk("setup copy", 8'hE4, ctrl.device_setup);
    chk("res copy", 8'h1F, ctrl.local_fraction_select);
    for (int k = 0; k < 13; k++)
      tsb_host_model_inst.write_reg(wp[k], 8'h00);
    for (int k = 0; k < 13; k++)
      rd_chk("cleared", rp[k], (k == 12) ? 8'h1C : 8'h00);
    done_test("write aliases");
    conv_pulse(1'b0, 12'hAB5);
    s0 = starts;
    for (int k = 0; k < 6; k++)
      tsb_host_model_inst.write_reg(ro[k], 8'hFF);
    rd_chk("local high", 8'h00, 8'hAB);
    rd_chk("status", 8'h02, EVF);
    chk("no start", 8'(s0), 8'(starts));
    tsb_host_model_inst.write_reg(8'h0F, 8'h00);
    tsb_host_model_inst.write_reg(8'h0F, 8'hFF);
    repeat (2) @(negedge clock);
    chk("one-shot pulses", 8'(s0 + 2), 8'(starts));
    rd_chk("one-shot read", 8'h0F, 8'h00);
    done_test("read-only and one-shot");
    tsb_host_model_inst.write_reg(8'h1A, 8'h03);
    rd_chk("local high", 8'h00, 8'hAB);
    // The conversion lands while the pointer moves to the low byte.
    fork
      conv_pulse(1'b0, 12'h3C9);
      rd_chk("low same conv", 8'h15, 8'h50);
    join
    rd_chk("other read", 8'h04, 8'h00);
    rd_chk("low new conv", 8'h15, 8'h90);
    conv_pulse(1'b1, 12'h7ED);
    tsb_host_model_inst.write_reg(8'h1A, 8'h00);
    rd_chk("remote high", 8'h01, 8'h7E);
    rd_chk("remote low", 8'h10, 8'hD0);
    conv_pulse(1'b0, 12'h12D);
    for (int r = 0; r < 4; r++)
    begin
      tsb_host_model_inst.write_reg(8'h1A, 8'(r));
      rd_chk("local fraction", 8'h15, 8'hD0 & fm[r]);
    end
    done_test("results and resolution");
    sys_rst = 1'b1;
    repeat (2) @(negedge clock);
    sys_rst = 1'b0;
    chk("pointer after reset", 8'h00, pointer);
    rd_chk("limit after reset", 8'h05, HLR);
    rd_chk("result after reset", 8'h00, 8'h00);
    done_test("second reset");
    conclude();
  end

  // The tests need well under a thousand cycles; this limit allows slack.
  initial
  begin
    repeat (5000) @(posedge clock);
    err_total++;
    conclude();
  end

endmodule : tb

`default_nettype wire
